// File: test/internal_osc_core_clock_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module internal_osc_core_clock_control_bench;
  logic        core_clk, rst, reg_wr, reg_rd, clr, core_clk_en;
  logic        osc_running, suspended, wake_pulse;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, osc_trim, count;
  logic [5:0]  wk;
  logic [3:0]  ext_div;
  logic        cmp_en;
  logic [31:0] rows [0:16];
  int          bad_count, checked, i, j;
  iosc_core_clock_ctrl iosc_core_clock_ctrl_inst (.core_clk(core_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_clk_tick(ext_div[1]),
    .rtc_clk_tick(ext_div[3]), .port0_match(wk[0]), .port1_match(wk[1]),
    .cmp0_enabled(cmp_en), .cmp0_out(~wk[2]), .cmp1_enabled(1'b1),
    .cmp1_out(~wk[3]), .rtc_osc_fail(wk[4]), .rtc_alarm(wk[5]),
    .core_clk_en(core_clk_en), .osc_running(osc_running),
    .osc_trim(osc_trim), .suspended(suspended), .wake_pulse(wake_pulse));
  iosc_core_model iosc_core_model_inst (.core_clk(core_clk), .clr(clr),
    .clk_en(core_clk_en), .count(count));
  task conclude;
    if (bad_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // enables seen in 128 cycles; any window works as periods divide 128
  task cnt(input logic [7:0] e);
    @(posedge core_clk);
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
    repeat (128) @(posedge core_clk);
    #1 chk(count, e);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // far-side sources: external rises every 4 cycles, rtc every 16
  always @(posedge core_clk) begin
    if (rst)
      ext_div <= 4'h0;
    else
      ext_div <= ext_div + 4'h1;
  end
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, clr} = 3'b000;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    wk = 6'h00;
    cmp_en = 1'b1;
    bad_count = 0;
    checked = 0;
    // address, write data, read back, enables per 128 cycles
    rows = '{32'hb35a_5a01, 32'hb280_c001, 32'hb281_c102, 32'hb282_c204,
      32'hb283_c308, 32'hb284_c410, 32'hb285_c520, 32'hb286_c640,
      32'hb287_c780, 32'hb29f_c780, 32'hb401_0120, 32'hb402_0208,
      32'hb403_0380, 32'hb510_1040, 32'hb500_0080, 32'hb400_0080,
      32'hb055_0080};
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    #1 chk(osc_trim, 8'h40);
    rd(8'hb2, 8'h80);
    repeat (12) @(posedge core_clk);
    rd(8'hb2, 8'hc0);
    rd(8'hb3, 8'h40);
    rd(8'hb4, 8'h00);
    for (i = 0; i < 17; i++) begin
      wr(rows[i][31:24], rows[i][23:16]);
      repeat (12) @(posedge core_clk);
      rd(rows[i][31:24], rows[i][15:8]);
      cnt(rows[i][7:0]);
    end
    for (i = 0; i < 6; i++) begin
      wr(8'hb2, 8'ha7);
      repeat (2) @(posedge core_clk);
      #1 chk({7'h0, suspended}, 8'h01);
      cnt(8'h00);
      @(posedge core_clk);
      wk[i] <= 1'b1;
      j = 0;
      while (wake_pulse !== 1'b1 && j < 20) begin
        @(posedge core_clk);
        #1 j++;
      end
      if (j == 20) begin
        bad_count++;
        conclude();
      end
      @(posedge core_clk);
      wk <= 6'h00;
      #1 chk({7'h0, suspended}, 8'h00);
      repeat (12) @(posedge core_clk);
      rd(8'hb2, 8'hc7);
      cnt(8'h80);
    end
    // a low comparator output must not wake while it is disabled
    wr(8'hb2, 8'ha7);
    cmp_en <= 1'b0;
    wk[2] <= 1'b1;
    repeat (8) @(posedge core_clk);
    #1 chk({7'h0, suspended}, 8'h01);
    @(posedge core_clk);
    cmp_en <= 1'b1;
    repeat (6) @(posedge core_clk);
    #1 chk({7'h0, suspended}, 8'h00);
    @(posedge core_clk);
    wk <= 6'h00;
    wr(8'hb2, 8'h07);
    repeat (3) @(posedge core_clk);
    #1 chk({7'h0, osc_running}, 8'h00);
    wr(8'hb2, 8'h87);
    repeat (12) @(posedge core_clk);
    #1 chk({7'h0, osc_running}, 8'h01);
    // reset in mid-run brings source, trim and divide back
    wr(8'hb4, 8'h03);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    #1 chk(osc_trim, 8'h40);
    rd(8'hb4, 8'h00);
    rd(8'hb2, 8'h80);
    conclude();
  end
endmodule
`default_nettype wire

// File: test/iosc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// core and peripheral side: counts the clock enables it is given
module iosc_core_model (
  input  wire logic       core_clk,
  input  wire logic       clr,
  input  wire logic       clk_en,
  output var  logic [7:0] count
);
  always @(posedge core_clk) begin
    count <= clr ? 8'h00 : count + {7'h0, clk_en};
  end
endmodule
`default_nettype wire

// File: test/iosc_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module iosc_ctrl_asserts (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       osc_running,
  input wire logic [7:0] osc_trim,
  input wire logic       suspended,
  input wire logic       wake_pulse
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  rd_idle_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read");
  unmapped_zero_a: assert property ($past(reg_rd)
    && ($past(reg_addr) < 8'hb2 || $past(reg_addr) > 8'hb5)
    |-> reg_rdata == 8'h00) else $error("unmapped read not zero");
  ctrl_unused_a: assert property ($past(reg_rd)
    && $past(reg_addr) == 8'hb2 |-> reg_rdata[4:3] == 2'b00)
    else $error("unused bits set");
  trim_write_a: assert property (reg_wr && reg_addr == 8'hb3
    |=> osc_trim == $past(reg_wdata)) else $error("trim not updated");
  suspend_entry_a: assert property (reg_wr && reg_addr == 8'hb2
    && reg_wdata[7] && reg_wdata[5] && !suspended |-> ##2 suspended)
    else $error("suspend not entered");
  suspend_halt_a: assert property (suspended |-> !osc_running)
    else $error("oscillator runs while suspended");
  enable_off_a: assert property (reg_wr && reg_addr == 8'hb2
    && !reg_wdata[7] |-> ##2 !osc_running) else $error("osc not disabled");
  wake_single_a: assert property (wake_pulse |=> !wake_pulse)
    else $error("wake pulse too long");
  wake_release_a: assert property (wake_pulse |=> !suspended)
    else $error("suspend not left after wake");
endmodule
bind iosc_core_clock_ctrl iosc_ctrl_asserts iosc_ctrl_asserts_inst (
  .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .osc_running(osc_running), .osc_trim(osc_trim),
  .suspended(suspended), .wake_pulse(wake_pulse));
`default_nettype wire

// File: verilog/iosc_core_clock_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "iosc_defines.vh"
module iosc_core_clock_ctrl (
  input  wire       core_clk,
  input  wire       rst,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  input  wire       ext_clk_tick,
  input  wire       rtc_clk_tick,
  input  wire       port0_match,
  input  wire       port1_match,
  input  wire       cmp0_enabled,
  input  wire       cmp0_out,
  input  wire       cmp1_enabled,
  input  wire       cmp1_out,
  input  wire       rtc_osc_fail,
  input  wire       rtc_alarm,
  output reg        core_clk_en,
  output reg        osc_running,
  output reg  [7:0] osc_trim,
  output reg        suspended,
  output reg        wake_pulse
);
  localparam [1:0] ST_RUN = 2'b01;
  localparam [1:0] ST_SUS = 2'b10;
  localparam integer SETTLE_FULL = `IOSC_SETTLE_CYC;
  localparam [7:0]   SETTLE      = SETTLE_FULL[7:0];

  reg  [1:0] state;
  reg        osc_en;
  reg  [2:0] div_sel;
  reg  [1:0] src_sel;
  reg  [1:0] mult_base;
  reg  [2:0] mult_scale;
  reg  [7:0] settle_cnt;
  reg        ready;
  reg  [5:0] wake_s1;
  reg  [5:0] wake_s2;
  reg  [5:0] tick_s1;
  reg  [5:0] tick_s2;
  reg  [2:0] frac_acc;
  reg        mult_tick;
  reg        next_clk_en;
  wire [3:0] acc_sum;
  wire [3:0] acc_left;
  wire       int_tick;
  wire       wake_any;
  wire       int_run;
  wire       ext_tick;
  wire       rtc_tick;
  wire       wr_ctrl;

  function [2:0] scale_den;
    input [2:0] s;
    begin
      if (s < 3'd3 || s > 3'd7)
        scale_den = 3'd2;
      else
        scale_den = s;
    end
  endfunction

  // pins from other domains: two flops before use
  always @(posedge core_clk) begin
    if (rst) begin
      wake_s1 <= 6'h00;
      wake_s2 <= 6'h00;
      tick_s1 <= 6'h00;
      tick_s2 <= 6'h00;
    end else begin
      wake_s1 <= {port0_match, port1_match,
                  cmp0_enabled & ~cmp0_out, cmp1_enabled & ~cmp1_out,
                  rtc_osc_fail, rtc_alarm};
      wake_s2 <= wake_s1;
      tick_s1 <= {4'h0, rtc_clk_tick, ext_clk_tick};
      // bits 3:2 keep the previous level for edge detection
      tick_s2 <= {2'b00, tick_s2[1:0], tick_s1[1:0]};
    end
  end

  assign wake_any = |wake_s2;
  assign ext_tick = tick_s2[0] & ~tick_s2[2];
  assign rtc_tick = tick_s2[1] & ~tick_s2[3];
  assign wr_ctrl  = reg_wr && (reg_addr == `IOSC_CTRL_OFS);
  assign int_run  = osc_en && (state == ST_RUN);
  // one spare bit so that acc + 2 cannot wrap for n = 7
  assign acc_sum  = {1'b0, frac_acc} + 4'h2;
  assign acc_left = acc_sum - {1'b0, scale_den(mult_scale)};

  iosc_divider u_div (
    .core_clk (core_clk),
    .rst      (rst),
    .run      (int_run),
    .code     (div_sel),
    .tick     (int_tick)
  );

  // register writes and suspend state
  always @(posedge core_clk) begin
    if (rst) begin
      osc_en     <= 1'b1;
      div_sel    <= 3'h0;
      src_sel    <= `IOSC_SRC_INT;
      osc_trim   <= `IOSC_CAL_RESET;
      mult_base  <= `IOSC_MB_INT2;
      mult_scale <= 3'h0;
      state      <= ST_RUN;
      wake_pulse <= 1'b0;
    end else begin
      wake_pulse <= 1'b0;
      case (state)
        ST_RUN: begin
          if (wr_ctrl && reg_wdata[`IOSC_CTRL_SUS_BIT])
            state <= ST_SUS;
        end
        ST_SUS: begin
          if (wake_any) begin
            state      <= ST_RUN;
            wake_pulse <= 1'b1;
          end
        end
        default: state <= ST_RUN;
      endcase
      if (reg_wr) begin
        if (reg_addr == `IOSC_CTRL_OFS) begin
          osc_en  <= reg_wdata[`IOSC_CTRL_EN_BIT];
          div_sel <= reg_wdata[`IOSC_DIV_MSB:`IOSC_DIV_LSB];
        end else if (reg_addr == `IOSC_CAL_OFS) begin
          osc_trim <= reg_wdata;
        end else if (reg_addr == `IOSC_CLKSEL_OFS) begin
          src_sel <= reg_wdata[1:0];
        end else if (reg_addr == `IOSC_MULT_OFS) begin
          mult_base  <= reg_wdata[1:0];
          mult_scale <= reg_wdata[4:2];
        end
      end
    end
  end

  // ready after settle time once running
  always @(posedge core_clk) begin
    if (rst) begin
      settle_cnt <= 8'h00;
      ready      <= 1'b0;
    end else if (!int_run || wr_ctrl) begin
      settle_cnt <= 8'h00;
      ready      <= 1'b0;
    end else if (settle_cnt >= SETTLE - 8'h01) begin
      ready <= 1'b1;
    end else begin
      settle_cnt <= settle_cnt + 8'h01;
    end
  end

  // multiplier: 2/n pulse swallowing on the core clock; base only selects the gating
  always @(posedge core_clk) begin
    if (rst) begin
      frac_acc  <= 3'h0;
      mult_tick <= 1'b0;
    end else begin
      mult_tick <= 1'b0;
      if (mult_scale == 3'h0) begin
        mult_tick <= 1'b1;
      end else if (acc_sum >= {1'b0, scale_den(mult_scale)}) begin
        frac_acc  <= acc_left[2:0];
        mult_tick <= 1'b1;
      end else begin
        frac_acc <= acc_sum[2:0];
      end
    end
  end

  // core clock enable; internal source gated while suspended
  always @* begin
    next_clk_en = 1'b0;
    case (src_sel)
      `IOSC_SRC_INT:  next_clk_en = int_tick;
      `IOSC_SRC_EXT:  next_clk_en = ext_tick;
      `IOSC_SRC_RTC:  next_clk_en = rtc_tick;
      default: begin
        if (mult_base == `IOSC_MB_INT2)
          next_clk_en = osc_en & (state == ST_RUN) & mult_tick;
        else
          next_clk_en = mult_tick;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (rst) begin
      core_clk_en <= 1'b0;
      osc_running <= 1'b0;
      suspended   <= 1'b0;
    end else begin
      core_clk_en <= next_clk_en;
      osc_running <= int_run;
      suspended   <= (state == ST_SUS);
    end
  end

  // read port: data one cycle after strobe
  always @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == `IOSC_CTRL_OFS)
        reg_rdata <= {osc_en, ready, 3'b000, div_sel};
      else if (reg_addr == `IOSC_CAL_OFS)
        reg_rdata <= osc_trim;
      else if (reg_addr == `IOSC_CLKSEL_OFS)
        reg_rdata <= {6'h00, src_sel};
      else if (reg_addr == `IOSC_MULT_OFS)
        reg_rdata <= {3'h0, mult_scale, mult_base};
      else
        reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// File: verilog/iosc_defines.vh
`ifndef IOSC_DEFINES_VH
`define IOSC_DEFINES_VH
// register map
`define IOSC_ADDR_W        8
`define IOSC_CTRL_OFS      8'hb2
`define IOSC_CAL_OFS       8'hb3
`define IOSC_CLKSEL_OFS    8'hb4
`define IOSC_MULT_OFS      8'hb5
// control register fields and reset
`define IOSC_CTRL_RESET    8'hc0
`define IOSC_CTRL_EN_BIT   7
`define IOSC_CTRL_RDY_BIT  6
`define IOSC_CTRL_SUS_BIT  5
`define IOSC_DIV_MSB       2
`define IOSC_DIV_LSB       0
// calibration factory value, arbitrary neutral code for 24.5 MHz
`define IOSC_CAL_RESET     8'h40
// clock source select codes
`define IOSC_SRC_INT       2'h0
`define IOSC_SRC_EXT       2'h1
`define IOSC_SRC_RTC       2'h2
`define IOSC_SRC_MULT      2'h3
`define IOSC_CLKSEL_RESET  8'h00
// multiplier: bits 1:0 base, bits 4:2 scale code
`define IOSC_MB_INT2       2'h0
`define IOSC_MB_EXT2       2'h1
`define IOSC_MB_EXT4       2'h2
`define IOSC_MULT_RESET    8'h00
// ready settle time after enable or wake
`define IOSC_SETTLE_NS     200
`define IOSC_CLK_NS        25
`define IOSC_SETTLE_CYC    ((`IOSC_SETTLE_NS + `IOSC_CLK_NS - 1) / `IOSC_CLK_NS)
`endif

// File: verilog/iosc_divider.v
`timescale 1ns/1ps
`default_nettype none
// power-of-two enable generator: one pulse every 2^(7-code) cycles
module iosc_divider (
  input  wire       core_clk,
  input  wire       rst,
  input  wire       run,
  input  wire [2:0] code,
  output reg        tick
);
  reg  [6:0] cnt;
  wire [6:0] last;

  function [6:0] div_last;
    input [2:0] c;
    begin
      div_last = 7'h7f >> c;
    end
  endfunction

  assign last = div_last(code);

  always @(posedge core_clk) begin
    if (rst) begin
      cnt  <= 7'h00;
      tick <= 1'b0;
    end else if (!run) begin
      tick <= 1'b0;
    end else if (cnt >= last) begin
      cnt  <= 7'h00;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + 7'h01;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire
